// ### shared/ssp_cfg.svh
// register offsets, field positions, reset values and width constants for the serial port
// assumes inclusion by the design file only
`ifndef SSP_CFG_SVH
`define SSP_CFG_SVH
// register indices; the apb byte address is four times the index (one word each)
`define SSP_IDX_TX_HOLD      16'hF480
`define SSP_IDX_RX_HOLD      16'hF482
`define SSP_IDX_MAIN_CTRL    16'hF486
`define SSP_IDX_MODE_CTRL    16'hF488
`define SSP_IDX_BAUD_CTRL    16'hF48A
`define SSP_IDX_SYS_CFG      16'hF48C
`define SSP_ADDR_W           20
// mode control fields
`define SSP_MODE_RXM         0
`define SSP_MODE_TXM         1
`define SSP_MODE_AUTO        2
`define SSP_MODE_RST         8'h00
// main control fields
`define SSP_MAIN_REN         0
`define SSP_MAIN_RIE         1
`define SSP_MAIN_RBF         2
`define SSP_MAIN_ROE         3
`define SSP_MAIN_TEN         4
`define SSP_MAIN_TIE         5
`define SSP_MAIN_TBE         6
`define SSP_MAIN_TUE         7
`define SSP_MAIN_RST         8'hC0
// baud control: bit 7 enable, 6..0 reload
`define SSP_BAUD_EN          7
`define SSP_BAUD_RST         8'h00
// system config: bit 0 tx data pin select, 1 rx clock pin select, 2 irq mux
`define SSP_SYS_TXPIN        0
`define SSP_SYS_RXCLKPIN     1
`define SSP_SYS_IRQMUX       2
`define SSP_SYS_RST          8'h00
`define SSP_WORD_TOP         4'hF
`define SSP_ZERO16           16'h0000
`endif

// ### shared/ssp_pkg.sv
// types shared by the serial port design
// assumes the cfg header is on the include path
package ssp_pkg;
  typedef struct packed {
    logic tx_clk_out;
    logic tx_clk_oe_n;
    logic rx_clk_out;
    logic rx_clk_oe_n;
    logic tx_data;
    logic tx_data_sel;
  } ssp_pins_type;
  typedef enum logic [1:0] {
    SSP_TX_IDLE  = 2'b00,
    SSP_TX_SHIFT = 2'b01,
    SSP_TX_HELD  = 2'b11
  } ssp_tx_state_type;
endpackage

// ### hw/ssp_core.sv
// synchronous serial port: apb slave, baud generator, 16-bit tx and rx shifters
// assumes pins arrive asynchronous to clock and are synchronised here
`timescale 1ns/1ps
`include "ssp_cfg.svh"
module ssp_core
  import ssp_pkg::*;
(
  // clock and reset
  input  wire logic        clock,
  input  wire logic        sys_rst,
  // apb slave
  input  wire logic                   psel,
  input  wire logic                   penable,
  input  wire logic                   pwrite,
  input  wire logic [`SSP_ADDR_W-1:0] paddr,
  input  wire logic [31:0]            pwdata,
  output logic      [31:0]            prdata,
  output logic                        pready,
  output logic                        pslverr,
  // serial pins
  input  wire logic        tx_clock_pin,
  input  wire logic        rx_clock_pin,
  input  wire logic        rx_data_pin,
  output ssp_pins_type     pins,
  // system requests
  output logic             serial_irq_request,
  output logic             tx_dma_request,
  output logic             rx_dma_request
);
  // ----------------------------------------
  // registers
  // ----------------------------------------
  logic [7:0]  serial_mode_control_reg;
  logic [7:0]  main_ctrl_reg;
  logic [7:0]  baud_ctrl_reg;
  logic [7:0]  sys_cfg_reg;
  logic [15:0] serial_tx_holding_word_reg;
  logic [15:0] serial_rx_holding_word_reg;
  logic [15:0] tx_shift_reg;
  logic [15:0] rx_shift_reg;
  logic [3:0]  tx_count_reg;
  logic [3:0]  rx_count_reg;
  logic [6:0]  baud_count_reg;
  logic        baud_clk_reg;
  logic        tbe_reg;
  logic        rbf_reg;
  logic        tue_reg;
  logic        roe_reg;
  logic        tx_data_reg;
  logic [1:0]  txc_sync_reg;
  logic [1:0]  rxc_sync_reg;
  logic [1:0]  rxd_sync_reg;
  logic        txc_last_reg;
  logic        rxc_last_reg;
  ssp_tx_state_type tx_state_reg;

  function automatic logic addr_hit(input logic [`SSP_ADDR_W-1:0] a, input logic [15:0] idx);
    addr_hit = (a == {{(`SSP_ADDR_W-18){1'b0}}, idx, 2'b00});
  endfunction

  // ----------------------------------------
  // apb access
  // ----------------------------------------
  logic acc;
  logic wr;
  logic rd;
  logic mapped;
  logic tx_master;
  logic rx_master;
  logic auto_tx;
  logic transmitter_enable;
  assign acc       = psel && penable;
  assign wr        = acc && pwrite;
  assign rd        = acc && !pwrite;
  assign pready    = 1'b1;
  assign tx_master = serial_mode_control_reg[`SSP_MODE_TXM];
  assign rx_master = serial_mode_control_reg[`SSP_MODE_RXM];
  assign auto_tx   = serial_mode_control_reg[`SSP_MODE_AUTO];
  assign transmitter_enable       = main_ctrl_reg[`SSP_MAIN_TEN];
  assign mapped    = addr_hit(paddr, `SSP_IDX_TX_HOLD) || addr_hit(paddr, `SSP_IDX_RX_HOLD)
                  || addr_hit(paddr, `SSP_IDX_MAIN_CTRL) || addr_hit(paddr, `SSP_IDX_MODE_CTRL)
                  || addr_hit(paddr, `SSP_IDX_BAUD_CTRL) || addr_hit(paddr, `SSP_IDX_SYS_CFG);
  assign pslverr   = acc && !mapped;

  logic [7:0] main_view;
  assign main_view = {tue_reg, tbe_reg, main_ctrl_reg[5:4], roe_reg, rbf_reg, main_ctrl_reg[1:0]};

  always_ff @(posedge clock) begin
    if (sys_rst) begin
      prdata <= 32'h0000_0000;
    end else if (psel && !penable && !pwrite) begin
      prdata <= 32'h0000_0000;
      if (addr_hit(paddr, `SSP_IDX_TX_HOLD))   prdata[15:0] <= serial_tx_holding_word_reg;
      if (addr_hit(paddr, `SSP_IDX_RX_HOLD))   prdata[15:0] <= serial_rx_holding_word_reg;
      if (addr_hit(paddr, `SSP_IDX_MAIN_CTRL)) prdata[7:0]  <= main_view;
      if (addr_hit(paddr, `SSP_IDX_MODE_CTRL)) prdata[7:0]  <= serial_mode_control_reg;
      if (addr_hit(paddr, `SSP_IDX_BAUD_CTRL)) prdata[7:0]  <= baud_ctrl_reg;
      if (addr_hit(paddr, `SSP_IDX_SYS_CFG))   prdata[7:0]  <= sys_cfg_reg;
    end
  end

  always_ff @(posedge clock) begin
    if (sys_rst) begin
      serial_mode_control_reg <= `SSP_MODE_RST;
      main_ctrl_reg           <= `SSP_MAIN_RST;
      baud_ctrl_reg           <= `SSP_BAUD_RST;
      sys_cfg_reg             <= `SSP_SYS_RST;
      serial_tx_holding_word_reg <= `SSP_ZERO16;
    end else if (wr) begin
      if (addr_hit(paddr, `SSP_IDX_MODE_CTRL)) serial_mode_control_reg <= {5'h00, pwdata[2:0]};
      if (addr_hit(paddr, `SSP_IDX_MAIN_CTRL)) main_ctrl_reg           <= pwdata[7:0];
      if (addr_hit(paddr, `SSP_IDX_BAUD_CTRL)) baud_ctrl_reg           <= pwdata[7:0];
      if (addr_hit(paddr, `SSP_IDX_SYS_CFG))   sys_cfg_reg             <= {5'h00, pwdata[2:0]};
      if (addr_hit(paddr, `SSP_IDX_TX_HOLD))   serial_tx_holding_word_reg <= pwdata[15:0];
    end
  end

  // ----------------------------------------
  // baud generator and pin synchronisers
  // ----------------------------------------
  always_ff @(posedge clock) begin
    if (sys_rst || !baud_ctrl_reg[`SSP_BAUD_EN]) begin
      baud_count_reg <= 7'h00;
      baud_clk_reg   <= 1'b0;
    end else if (baud_count_reg == 7'h00) begin
      baud_count_reg <= baud_ctrl_reg[6:0];
      baud_clk_reg   <= !baud_clk_reg;
    end else begin
      baud_count_reg <= baud_count_reg - 7'h01;
    end
  end

  // rx data and tx clock pins are plain inputs with no select
  always_ff @(posedge clock) begin
    if (sys_rst) begin
      txc_sync_reg <= 2'b00;
      rxc_sync_reg <= 2'b00;
      rxd_sync_reg <= 2'b00;
      txc_last_reg <= 1'b0;
      rxc_last_reg <= 1'b0;
    end else begin
      txc_sync_reg <= {txc_sync_reg[0], tx_clock_pin};
      rxc_sync_reg <= {rxc_sync_reg[0], rx_clock_pin};
      rxd_sync_reg <= {rxd_sync_reg[0], rx_data_pin};
      txc_last_reg <= tx_master ? baud_clk_reg : txc_sync_reg[1];
      rxc_last_reg <= rx_master ? baud_clk_reg : rxc_sync_reg[1];
    end
  end

  logic txc_now;
  logic rxc_now;
  logic tx_fall;
  logic rx_rise;
  assign txc_now = tx_master ? baud_clk_reg : txc_sync_reg[1];
  assign rxc_now = rx_master ? baud_clk_reg : rxc_sync_reg[1];
  assign tx_fall = txc_last_reg && !txc_now;
  assign rx_rise = !rxc_last_reg && rxc_now;

  // ----------------------------------------
  // transmitter
  // ----------------------------------------
  logic tx_go;
  logic tx_load;
  logic tx_last_bit;
  logic hold_write;
  assign tx_go       = (tx_master && auto_tx) ? 1'b1 : transmitter_enable;
  assign hold_write  = wr && addr_hit(paddr, `SSP_IDX_TX_HOLD);
  assign tx_last_bit = tx_state_reg == SSP_TX_SHIFT && tx_fall && tx_count_reg == 4'h0;
  // load only when idle or the previous word just finished
  assign tx_load     = !tbe_reg && (tx_state_reg == SSP_TX_IDLE || tx_last_bit);

  always_ff @(posedge clock) begin
    if (sys_rst) begin
      tx_state_reg <= SSP_TX_IDLE;
      tx_shift_reg <= `SSP_ZERO16;
      tx_count_reg <= 4'h0;
      tx_data_reg  <= 1'b0;
    end else begin
      if (tx_load) begin
        tx_shift_reg <= serial_tx_holding_word_reg;
        tx_count_reg <= `SSP_WORD_TOP;
        tx_state_reg <= tx_go ? SSP_TX_SHIFT : SSP_TX_HELD;
      end else if (tx_last_bit) begin
        tx_state_reg <= SSP_TX_IDLE; // auto mode stops here
      end else if (tx_state_reg == SSP_TX_HELD && tx_go) begin
        tx_state_reg <= SSP_TX_SHIFT;
      end
      // the last bit still leaves when the next word loads on the same edge
      if (tx_state_reg == SSP_TX_SHIFT && tx_fall) begin
        tx_data_reg  <= tx_shift_reg[15]; // msb first, on falling edge
      end
      if (tx_state_reg == SSP_TX_SHIFT && tx_fall && !tx_load) begin
        tx_shift_reg <= {tx_shift_reg[14:0], 1'b0};
        tx_count_reg <= tx_count_reg - 4'h1;
      end
    end
  end

  // set wins over a same-cycle clear
  always_ff @(posedge clock) begin
    if (sys_rst) begin
      tbe_reg <= 1'b1;
      tue_reg <= 1'b1;
    end else begin
      if (tx_load)         tbe_reg <= 1'b1;
      else if (hold_write) tbe_reg <= 1'b0;
      if (tx_last_bit && tbe_reg && transmitter_enable && !auto_tx) tue_reg <= 1'b1;
      else if (wr && addr_hit(paddr, `SSP_IDX_MAIN_CTRL) && !pwdata[`SSP_MAIN_TUE])
        tue_reg <= 1'b0;
    end
  end

  // ----------------------------------------
  // receiver
  // ----------------------------------------
  logic rx_done;
  logic rbuf_read;
  assign rx_done   = main_ctrl_reg[`SSP_MAIN_REN] && rx_rise && rx_count_reg == 4'h0;
  assign rbuf_read = rd && addr_hit(paddr, `SSP_IDX_RX_HOLD);

  always_ff @(posedge clock) begin
    if (sys_rst || !main_ctrl_reg[`SSP_MAIN_REN]) begin
      rx_shift_reg <= `SSP_ZERO16;
      rx_count_reg <= `SSP_WORD_TOP;
    end else if (rx_rise) begin
      rx_shift_reg <= {rx_shift_reg[14:0], rxd_sync_reg[1]};
      rx_count_reg <= rx_count_reg - 4'h1;
    end
  end

  always_ff @(posedge clock) begin
    if (sys_rst) begin
      serial_rx_holding_word_reg <= `SSP_ZERO16;
      rbf_reg <= 1'b0;
      roe_reg <= 1'b0;
    end else begin
      if (rx_done) serial_rx_holding_word_reg <= {rx_shift_reg[14:0], rxd_sync_reg[1]};
      if (rx_done)        rbf_reg <= 1'b1;
      else if (rbuf_read) rbf_reg <= 1'b0;
      if (rx_done && rbf_reg) roe_reg <= 1'b1;
      else if (wr && addr_hit(paddr, `SSP_IDX_MAIN_CTRL) && !pwdata[`SSP_MAIN_ROE])
        roe_reg <= 1'b0;
    end
  end

  // ----------------------------------------
  // pins and requests
  // ----------------------------------------
  logic irq_raw;
  assign irq_raw = (tbe_reg && main_ctrl_reg[`SSP_MAIN_TIE])
                || (rbf_reg && main_ctrl_reg[`SSP_MAIN_RIE]);

  always_ff @(posedge clock) begin
    if (sys_rst) begin
      pins <= '{tx_clk_out: 1'b0, tx_clk_oe_n: 1'b1, rx_clk_out: 1'b0, rx_clk_oe_n: 1'b1,
                tx_data: 1'b0, tx_data_sel: 1'b0};
      serial_irq_request <= 1'b0;
      tx_dma_request     <= 1'b0;
      rx_dma_request     <= 1'b0;
    end else begin
      pins.tx_clk_out  <= baud_clk_reg;
      pins.tx_clk_oe_n <= !tx_master;
      pins.rx_clk_out  <= baud_clk_reg;
      pins.rx_clk_oe_n <= !(rx_master && !sys_cfg_reg[`SSP_SYS_RXCLKPIN]);
      pins.tx_data     <= tx_data_reg;
      pins.tx_data_sel <= !sys_cfg_reg[`SSP_SYS_TXPIN];
      serial_irq_request <= irq_raw && !sys_cfg_reg[`SSP_SYS_IRQMUX];
      tx_dma_request     <= tbe_reg;
      rx_dma_request     <= rbf_reg;
    end
  end

  // ----------------------------------------
  // checks
  // ----------------------------------------
  sequence tx_word_loaded;
    tx_load;
  endsequence

  tbe_on_load_a: assert property (@(posedge clock) disable iff (sys_rst)
    tx_word_loaded |=> tbe_reg)
    else $error("tx empty not set after load");
  tbe_clear_a: assert property (@(posedge clock) disable iff (sys_rst)
    hold_write && !tx_load |=> !tbe_reg)
    else $error("tx empty not cleared by write");
  rbf_set_a: assert property (@(posedge clock) disable iff (sys_rst)
    rx_done |=> rbf_reg
      && (serial_rx_holding_word_reg == {$past(rx_shift_reg[14:0]), $past(rxd_sync_reg[1])}))
    else $error("rx word not captured");
  rbf_clear_a: assert property (@(posedge clock) disable iff (sys_rst)
    rbuf_read && !rx_done |=> !rbf_reg)
    else $error("rx full not cleared by read");
  held_stays_a: assert property (@(posedge clock) disable iff (sys_rst)
    tx_state_reg == SSP_TX_HELD && !tx_go |=> tx_state_reg == SSP_TX_HELD)
    else $error("held word lost while disabled");
  gate_norm_a: assert property (@(posedge clock) disable iff (sys_rst)
    tx_load && !auto_tx && !transmitter_enable |=> tx_state_reg == SSP_TX_HELD)
    else $error("disabled transmitter started");
  auto_go_a: assert property (@(posedge clock) disable iff (sys_rst)
    tx_load && auto_tx && tx_master |=> tx_state_reg == SSP_TX_SHIFT)
    else $error("auto mode did not start");
  msb_first_a: assert property (@(posedge clock) disable iff (sys_rst)
    tx_state_reg == SSP_TX_SHIFT && tx_fall && !tx_load |=> tx_data_reg == $past(tx_shift_reg[15]))
    else $error("tx bit order wrong");
  irq_mux_a: assert property (@(posedge clock) disable iff (sys_rst)
    sys_cfg_reg[`SSP_SYS_IRQMUX] |=> !serial_irq_request)
    else $error("irq passed while muxed away");
  tx_clk_drv_a: assert property (@(posedge clock) disable iff (sys_rst)
    tx_master |=> !pins.tx_clk_oe_n)
    else $error("tx clock not driven in master");
endmodule

// ### testbench/ssp_partner.sv
// external synchronous serial device facing the core's pins
// assumes the system clock is shared and the pin struct comes straight from the core
`timescale 1ns/1ps
module ssp_partner
  import ssp_pkg::*;
(
  // system clock
  input  wire logic   clock,
  // serial pins
  input  wire ssp_pins_type pins,
  output logic        tx_clock_pin,
  output logic        rx_clock_pin,
  output logic        rx_data_pin
);
  logic [15:0] cap = 16'h0000;
  logic [4:0]  cnt = 5'h00;
  logic        tck_d = 1'b1;
  logic        seen = 1'b0;
  wire         tck = pins.tx_clk_oe_n ? tx_clock_pin : pins.tx_clk_out;

  initial begin
    tx_clock_pin = 1'b1;
    rx_clock_pin = 1'b1;
    rx_data_pin  = 1'b0;
  end
  // ----------------------------------------
  // capture of transmitted words
  // ----------------------------------------
  // freezes after sixteen bits so an idle clock cannot shift the word away;
  // a rise before the first fall carries no data (master clock starts low)
  always @(posedge clock) begin
    tck_d <= tck;
    if (!tck && tck_d) seen <= 1'b1;
    if (tck && !tck_d && seen && cnt < 5'h10) begin
      cap <= {cap[14:0], pins.tx_data};
      cnt <= cnt + 5'h01;
    end
  end
  task automatic clear;
    cnt  = 5'h00;
    seen = 1'b0;
  endtask
  // clock stands still between frames; 160 ns period stays below the tx limit
  task automatic clock_tx(input int bits);
    repeat (bits) begin
      @(posedge clock);
      tx_clock_pin <= 1'b0;
      repeat (8) @(posedge clock);
      tx_clock_pin <= 1'b1;
      repeat (7) @(posedge clock);
    end
  endtask
  // data changes on the falling edge; released line shows the inverse
  task automatic send_word(input logic [15:0] w);
    for (int i = 15; i >= 0; i--) begin
      @(posedge clock);
      rx_clock_pin <= 1'b0;
      rx_data_pin  <= w[i];
      repeat (4) @(posedge clock);
      rx_clock_pin <= 1'b1;
      repeat (3) @(posedge clock);
    end
    @(posedge clock);
    rx_data_pin <= ~w[0];
  endtask
endmodule

// ### testbench/ssp_core_test.sv
// self-checking bench: apb register sequences against the serial partner
// assumes the package, the core and ssp_partner are compiled first
`timescale 1ns/1ps
module ssp_core_test
  import ssp_pkg::*;
;
  logic         clock = 1'b0;
  logic         sys_rst = 1'b1;
  logic         psel = 1'b0;
  logic         penable = 1'b0;
  logic         pwrite = 1'b0;
  logic [19:0]  paddr = 20'h00000;
  logic [31:0]  pwdata = 32'h00000000;
  logic [31:0]  prdata;
  logic         pready, pslverr, last_err;
  logic         serial_irq_request, tx_dma_request, rx_dma_request;
  logic         tx_clock_pin, rx_clock_pin, rx_data_pin;
  ssp_pins_type pins;
  int           fail_count = 0;
  int           check_count = 0;
  int           cycles = 0;
  // byte addresses: four times each register index
  localparam logic [19:0] A_TXH  = 20'h3D200;
  localparam logic [19:0] A_RXH  = 20'h3D208;
  localparam logic [19:0] A_MAIN = 20'h3D218;
  localparam logic [19:0] A_MODE = 20'h3D220;
  localparam logic [19:0] A_BAUD = 20'h3D228;
  localparam logic [19:0] A_SYS  = 20'h3D230;
  localparam logic [19:0] A_NONE = 20'h3D280;

  always #5 clock = ~clock;
  ssp_core DUT (.clock(clock), .sys_rst(sys_rst), .psel(psel), .penable(penable),
    .pwrite(pwrite), .paddr(paddr), .pwdata(pwdata), .prdata(prdata), .pready(pready),
    .pslverr(pslverr), .tx_clock_pin(tx_clock_pin), .rx_clock_pin(rx_clock_pin),
    .rx_data_pin(rx_data_pin), .pins(pins), .serial_irq_request(serial_irq_request),
    .tx_dma_request(tx_dma_request), .rx_dma_request(rx_dma_request));
  ssp_partner PRT (.clock(clock), .pins(pins), .tx_clock_pin(tx_clock_pin),
    .rx_clock_pin(rx_clock_pin), .rx_data_pin(rx_data_pin));
  // ----------------------------------------
  // shared tasks
  // ----------------------------------------
  task automatic chk(input logic [31:0] got, input logic [31:0] exp);
    check_count++;
    if (got !== exp) begin
      fail_count++;
      $display("mismatch at %0t: got %h expected %h", $time, got, exp);
    end
  endtask
  task automatic apb(input logic wr, input logic [19:0] a, input logic [31:0] d,
                     output logic [31:0] r);
    int n;
    n = 0;
    @(posedge clock);
    psel    <= 1'b1;
    pwrite  <= wr;
    paddr   <= a;
    pwdata  <= d;
    @(posedge clock);
    penable <= 1'b1;
    @(posedge clock);
    while (pready !== 1'b1 && n < 50) begin
      @(posedge clock);
      n++;
    end
    r        = prdata;
    last_err = pslverr;
    psel    <= 1'b0;
    penable <= 1'b0;
  endtask
  task automatic wr(input logic [19:0] a, input logic [31:0] d);
    logic [31:0] r;
    apb(1'b1, a, d, r);
  endtask
  task automatic rdc(input logic [19:0] a, input logic [31:0] e);
    logic [31:0] r;
    apb(1'b0, a, 32'h00000000, r);
    chk(r, e);
  endtask
  task automatic settle;
    repeat (3) @(posedge clock);
  endtask
  task automatic wait_word;
    int n;
    n = 0;
    while (PRT.cnt !== 5'h10 && n < 3000) begin
      @(posedge clock);
      n++;
    end
  endtask
  task automatic end_sim;
    $display("checks %0d mismatches %0d", check_count, fail_count);
    if (fail_count == 0 && check_count > 0)
      $display("ALL TESTS PASSED");
    else
      $display("TESTS FAILED");
    $finish;
  endtask
  // a hang counts as a mismatch
  always @(posedge clock) begin
    cycles++;
    if (cycles == 20000) begin
      fail_count++;
      end_sim();
    end
  end
  // ----------------------------------------
  // scenarios
  // ----------------------------------------
  initial begin
    repeat (8) @(posedge clock);
    sys_rst <= 1'b0;
    rdc(A_MODE, 32'h0);
    rdc(A_MAIN, 32'hC0);
    rdc(A_RXH, 32'h0);
    chk(tx_dma_request, 1'b1);
    wr(A_RXH, 32'hFFFF);
    rdc(A_RXH, 32'h0);
    wr(A_MODE, 32'hF8);
    rdc(A_MODE, 32'h0);
    rdc(A_NONE, 32'h0);
    chk(last_err, 1'b1);
    // slave receive; the write of 0 to the underrun bit clears it
    wr(A_MAIN, 32'h01);
    PRT.send_word(16'hA5C3);
    settle();
    chk(pins.rx_clk_oe_n, 1'b1);
    chk(rx_dma_request, 1'b1);
    rdc(A_MAIN, 32'h45);
    rdc(A_RXH, 32'hA5C3);
    settle();
    chk(rx_dma_request, 1'b0);
    // slave transmit: the idle shifter takes the word at once, held until enabled
    wr(A_TXH, 32'h9B31);
    settle();
    chk(tx_dma_request, 1'b1);
    PRT.clear();
    wr(A_MAIN, 32'h11);
    settle();
    chk(tx_dma_request, 1'b1);
    wr(A_TXH, 32'h6E4C);
    settle();
    chk(tx_dma_request, 1'b0);
    PRT.clock_tx(16);
    chk(PRT.cap, 16'h9B31);
    PRT.clear();
    PRT.clock_tx(16);
    chk(PRT.cap, 16'h6E4C);
    // master transmit held while disabled; the baud clock runs during the hold,
    // then restarts from low so the partner frames the word from its first fall
    wr(A_MAIN, 32'h01);
    wr(A_BAUD, 32'h83);
    wr(A_MODE, 32'h02);
    settle();
    chk(pins.tx_clk_oe_n, 1'b0);
    wr(A_TXH, 32'hC35A);
    repeat (100) @(posedge clock);
    chk(pins.tx_data, 1'b0);
    wr(A_BAUD, 32'h00);
    PRT.clear();
    wr(A_MAIN, 32'h11);
    wr(A_BAUD, 32'h83);
    wait_word();
    chk(PRT.cap, 16'hC35A);
    // automatic transmit ignores the enable
    wr(A_BAUD, 32'h00);
    wr(A_MAIN, 32'h01);
    wr(A_MODE, 32'h06);
    PRT.clear();
    wr(A_TXH, 32'h1F08);
    wr(A_BAUD, 32'h83);
    wait_word();
    chk(PRT.cap, 16'h1F08);
    // receive master clock pin and pin selects
    wr(A_MODE, 32'h01);
    settle();
    chk(pins.rx_clk_oe_n, 1'b0);
    wr(A_SYS, 32'h02);
    settle();
    chk(pins.rx_clk_oe_n, 1'b1);
    chk(pins.tx_data_sel, 1'b1);
    wr(A_SYS, 32'h01);
    settle();
    chk(pins.tx_data_sel, 1'b0);
    // interrupt routing through the shared line
    wr(A_SYS, 32'h00);
    wr(A_MAIN, 32'h21);
    settle();
    chk(serial_irq_request, 1'b1);
    wr(A_SYS, 32'h04);
    settle();
    chk(serial_irq_request, 1'b0);
    end_sim();
  end
endmodule
